//--- verif/mgmt_host.sv
// management host model issuing register reads and writes
module mgmt_host (
  input  wire logic                     clk,
  input  wire phy_regs_pkg::reg_word_t  reg_rdata,
  output logic                          reg_rd,
  output logic                          reg_wr,
  output phy_regs_pkg::reg_num_t        reg_addr,
  output phy_regs_pkg::reg_word_t       reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import phy_regs_pkg::*;
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input reg_num_t a, input reg_word_t d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // data registered at the taking edge, so read at the next low phase
  task automatic rd(input reg_num_t a, output reg_word_t d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  task automatic ram_rd(input logic [7:0] loc, output reg_word_t d);
    wr(5'h16, 16'h8004);
    wr(5'h14, {8'h00, loc});
    rd(5'h13, d);
  endtask
  task automatic skew_rd(output reg_word_t d, output logic ok);
    reg_word_t s;
    wr(5'h16, 16'h8005);
    rd(5'h15, s);
    ok = s[6];
    d = 16'h0000;
    if (ok) rd(5'h14, d);
  endtask
endmodule

//--- verif/phy_paged_status_diag_regs_test.sv
// self-checking bench for the paged status and diagnostic register bank
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  fails++; $display("wrong value at %0t: got %h want %h", $time, got, exp); \
  end end
module phy_paged_status_diag_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import phy_regs_pkg::*;
  logic clk, rst_b, soft_rst, reg_rd, reg_wr, serial_gig_mode;
  logic ms_resolve_fail, parallel_detect_fault, no_common_mode;
  logic link_fail_after_neg, elastic_buf_error, rx_symbol_error;
  logic rx_false_carrier, ram_we, diag_valid, cd_crossover, ab_crossover;
  logic auto_medium_sel, tx_class_a, pd_detect_en, force_neg_polarity;
  logic [14:0] copper_events;
  logic [5:0]  fiber_events;
  logic [7:0]  ram_rdata, ram_addr, ram_wdata, cable_distance, page_num;
  logic [1:0]  cable_result;
  logic [4:0]  cable_amplitude;
  logic [15:0] pair_skew_in;
  logic [3:0]  pair_polarity, pd_drop_hyst;
  reg_num_t     reg_addr;
  reg_word_t    reg_wdata, reg_rdata;
  test_select_t test_select;
  int fails, total_checks, cycles;
  // byte store stand-in: contents derived from the address
  assign ram_rdata = ram_addr ^ 8'ha5;
  phy_paged_status_diag_regs i_phy_paged_status_diag_regs (.*);
  mgmt_host i_mgmt_host (.clk, .reg_rdata, .reg_rd, .reg_wr, .reg_addr,
    .reg_wdata);
  //////////////////////////////////////////////////////////////////////////
  task automatic rd(input reg_num_t a, output reg_word_t d);
    i_mgmt_host.rd(a, d);
  endtask
  task automatic wr(input reg_num_t a, input reg_word_t d);
    i_mgmt_host.wr(a, d);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    reg_word_t d;
    rd(5'h16, d); `CHK(d, 16'h8000)
    `CHK(auto_medium_sel, 1'b1)
    rd(5'h1a, d); `CHK(d, 16'h0040)
    `CHK(pd_drop_hyst, 4'h4)
    rd(5'h15, d); `CHK(d, 16'h0000)
    `CHK(ram_addr, 8'h00)
  endtask
  task automatic t_copper;
    reg_word_t d;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      {ms_resolve_fail, parallel_detect_fault, no_common_mode,
        link_fail_after_neg} = 4'h1 << k;
      @(negedge clk);
      {ms_resolve_fail, parallel_detect_fault, no_common_mode,
        link_fail_after_neg} = 4'h0;
      rd(5'h13, d); `CHK(d, 16'h8000)
    end
    for (int i = 0; i < 15; i++) begin
      @(negedge clk);
      copper_events = 15'h0001 << i;
      @(negedge clk);
      copper_events = 15'h0000;
      rd(5'h13, d); `CHK(d, (i == 3 || i == 7) ? 16'h0 : 16'h1 << i)
      rd(5'h13, d); `CHK(d, 16'h0000)
    end
    // event held across the read edge must survive that read
    copper_events = 15'h0001;
    rd(5'h13, d); `CHK(d, 16'h0001)
    copper_events = 15'h0000;
    rd(5'h13, d); `CHK(d, 16'h0001)
    rd(5'h13, d); `CHK(d, 16'h0000)
  endtask
  task automatic t_fiber_mac;
    reg_word_t d;
    wr(5'h16, 16'h8001);
    rd(5'h13, d);
    for (int s = 0; s < 2; s++) begin
      serial_gig_mode = s[0];
      @(negedge clk);
      fiber_events = 6'h3f;
      copper_events = 15'h0008;
      @(negedge clk);
      fiber_events = 6'h00;
      copper_events = 15'h0000;
      rd(5'h13, d); `CHK(d, s ? 16'h0310 : 16'h3f10)
      rd(5'h13, d); `CHK(d, 16'h0000)
    end
    wr(5'h16, 16'h8002);
    @(negedge clk);
    elastic_buf_error = 1'b1;
    @(negedge clk);
    elastic_buf_error = 1'b0;
    rd(5'h13, d); `CHK(d, 16'h0080)
    rd(5'h13, d); `CHK(d, 16'h0000)
  endtask
  task automatic t_counter;
    reg_word_t d;
    wr(5'h16, 16'h8000);
    @(negedge clk);
    rx_symbol_error = 1'b1;
    copper_events = 15'h4000;
    @(negedge clk);
    {rx_symbol_error, rx_false_carrier, soft_rst} = 3'b011;
    copper_events = 15'h0000;
    @(negedge clk);
    {rx_symbol_error, rx_false_carrier, soft_rst} = 3'b110;
    @(negedge clk);
    {rx_symbol_error, rx_false_carrier} = 2'b00;
    rd(5'h13, d); `CHK(d, 16'h0000)
    rd(5'h15, d); `CHK(d, 16'h0004)
    {rx_symbol_error, rx_false_carrier} = 2'b11;
    // two per cycle, so this passes the ceiling
    repeat (32770) @(negedge clk);
    {rx_symbol_error, rx_false_carrier} = 2'b00;
    rd(5'h15, d); `CHK(d, 16'hffff)
    rd(5'h15, d); `CHK(d, 16'h0000)
  endtask
  task automatic t_ram_diag;
    reg_word_t d;
    logic ok;
    i_mgmt_host.ram_rd(8'h5a, d); `CHK(d, 16'h00ff)
    `CHK(ram_addr, 8'h5a)
    wr(5'h13, 16'h1234);
    wr(5'h16, 16'h8005);
    for (int c = 0; c < 4; c++) begin
      cable_result = c[1:0];
      cable_amplitude = (c == 0) ? 5'h1f : (c == 1) ? 5'h10 : 5'h00;
      cable_distance = 8'h11 * c[7:0];
      rd(5'h13, d);
      `CHK(d[14:0], {c[1:0], cable_amplitude, cable_distance})
    end
    {pair_skew_in, diag_valid, cd_crossover, ab_crossover} = {16'hf1a4, 3'b110};
    pair_polarity = 4'h9;
    i_mgmt_host.skew_rd(d, ok); `CHK({ok, d}, {1'b1, 16'hf1a4})
    rd(5'h15, d); `CHK(d, 16'h0069)
    {diag_valid, cd_crossover, ab_crossover, pair_polarity} = 7'h16;
    rd(5'h15, d); `CHK(d, 16'h0016)
  endtask
  task automatic t_control;
    reg_word_t d;
    wr(5'h16, 16'h8000);
    wr(5'h1a, 16'hffff);
    rd(5'h1a, d); `CHK(d, 16'hfdfe)
    `CHK({tx_class_a, pd_detect_en, pd_drop_hyst}, 6'h3f)
    `CHK(force_neg_polarity, 1'b1)
    for (int t = 0; t < 4; t++) begin
      wr(5'h1a, {12'h000, t[1:0], 2'b00});
      `CHK({tx_class_a, test_select}, {1'b0, t[1:0]})
    end
    wr(5'h16, 16'hffff);
    rd(5'h16, d); `CHK(d, 16'h80ff)
    rd(5'h13, d); `CHK(d, 16'h0000)
    wr(5'h16, 16'h0000);
    `CHK({auto_medium_sel, page_num}, 9'h000)
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    {rst_b, soft_rst, serial_gig_mode, elastic_buf_error} = 4'h0;
    {ms_resolve_fail, parallel_detect_fault, no_common_mode} = 3'h0;
    {link_fail_after_neg, rx_symbol_error, rx_false_carrier} = 3'h0;
    {copper_events, fiber_events, cable_result} = '0;
    {cable_amplitude, cable_distance, pair_skew_in} = '0;
    {diag_valid, cd_crossover, ab_crossover, pair_polarity} = '0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    t_reset;
    t_copper;
    t_fiber_mac;
    t_counter;
    t_ram_diag;
    t_control;
    tally_and_finish;
  end
endmodule
bind phy_paged_status_diag_regs phy_regs_chk i_phy_regs_chk (.clk, .rst_b,
  .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .ram_addr, .ram_we,
  .ram_wdata, .page_num, .auto_medium_sel, .tx_class_a, .pd_detect_en,
  .pd_drop_hyst, .test_select, .force_neg_polarity, .cable_result,
  .cable_amplitude, .cable_distance, .pair_skew_in, .diag_valid,
  .cd_crossover, .ab_crossover, .pair_polarity);

//--- verif/phy_regs_chk.sv
// port assertions for the paged status and diagnostic register bank
module phy_regs_chk (
  input wire logic                      clk,
  input wire logic                      rst_b,
  input wire logic                      reg_rd,
  input wire logic                      reg_wr,
  input wire phy_regs_pkg::reg_num_t    reg_addr,
  input wire phy_regs_pkg::reg_word_t   reg_wdata,
  input wire phy_regs_pkg::reg_word_t   reg_rdata,
  input wire logic [7:0]                ram_addr,
  input wire logic                      ram_we,
  input wire logic [7:0]                ram_wdata,
  input wire logic [7:0]                page_num,
  input wire logic                      auto_medium_sel,
  input wire logic                      tx_class_a,
  input wire logic                      pd_detect_en,
  input wire logic [3:0]                pd_drop_hyst,
  input wire phy_regs_pkg::test_select_t test_select,
  input wire logic                      force_neg_polarity,
  input wire logic [1:0]                cable_result,
  input wire logic [4:0]                cable_amplitude,
  input wire logic [7:0]                cable_distance,
  input wire logic [15:0]               pair_skew_in,
  input wire logic                      diag_valid,
  input wire logic                      cd_crossover,
  input wire logic                      ab_crossover,
  input wire logic [3:0]                pair_polarity
);
  timeunit 1ns;
  timeprecision 100ps;
  import phy_regs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic cfg_wr;
  logic diag_rd;
  // control register lives on page 0 only
  assign cfg_wr  = reg_wr && reg_addr == 5'h1a && page_num == 8'h00;
  assign diag_rd = reg_rd && page_num == 8'h05;
  //////////////////////////////////////////////////////////////////////////
  property p_page_wr;
    reg_wr && reg_addr == 5'h16 |=> page_num == $past(reg_wdata[7:0])
      && auto_medium_sel == $past(reg_wdata[15]);
  endproperty
  a_page_wr: assert property (p_page_wr)
    else $error("page select write not applied");
  property p_tx_class;
    cfg_wr |=> tx_class_a == $past(reg_wdata[15]);
  endproperty
  a_tx_class: assert property (p_tx_class)
    else $error("transmitter class not applied");
  property p_pd;
    cfg_wr |=> pd_detect_en == $past(reg_wdata[8])
      && pd_drop_hyst == $past(reg_wdata[7:4]);
  endproperty
  a_pd: assert property (p_pd)
    else $error("detection controls not applied");
  property p_test_sel;
    cfg_wr |=> test_select == $past(reg_wdata[3:2]);
  endproperty
  a_test_sel: assert property (p_test_sel)
    else $error("test select not applied");
  property p_force_pol;
    cfg_wr |=> force_neg_polarity == $past(reg_wdata[1]);
  endproperty
  a_force_pol: assert property (p_force_pol)
    else $error("polarity force not applied");
  property p_ram_we;
    reg_wr && reg_addr == 5'h13 && page_num == 8'h04
      |-> ram_we && ram_wdata == reg_wdata[7:0];
  endproperty
  a_ram_we: assert property (p_ram_we)
    else $error("ram byte write missing");
  property p_ram_addr;
    reg_wr && reg_addr == 5'h14 && page_num == 8'h04
      |=> ram_addr == $past(reg_wdata[7:0]);
  endproperty
  a_ram_addr: assert property (p_ram_addr)
    else $error("ram byte address not applied");
  property p_cable;
    diag_rd && reg_addr == 5'h13 |=> reg_rdata[14:0] == {$past(cable_result),
      $past(cable_amplitude), $past(cable_distance)};
  endproperty
  a_cable: assert property (p_cable)
    else $error("cable result read wrong");
  property p_skew;
    diag_rd && reg_addr == 5'h14 |=> reg_rdata == $past(pair_skew_in);
  endproperty
  a_skew: assert property (p_skew)
    else $error("pair skew read wrong");
  property p_swap;
    diag_rd && reg_addr == 5'h15 |=> reg_rdata == {9'h000, $past(diag_valid),
      $past(cd_crossover), $past(ab_crossover), $past(pair_polarity)};
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap and polarity read wrong");
endmodule

//--- verilog/latched_high_bank.sv
// bank of latched_high event bits, cleared by read without losing events
module latched_high_bank #(
  parameter int          WIDTH = 16,
  parameter logic [15:0] MASK  = 16'hffff
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             soft_rst,
  input  wire logic [WIDTH-1:0] event_in,
  input  wire logic             read_clear,
  output logic      [WIDTH-1:0] status
);
  logic [WIDTH-1:0] status_reg;

  assign status = status_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      if (MASK[i]) begin : g_live
        always_ff @(posedge clk or negedge rst_b) begin
          if (!rst_b) begin
            status_reg[i] <= 1'b0;
          end else if (soft_rst) begin
            status_reg[i] <= 1'b0;
          end else if (event_in[i]) begin
            status_reg[i] <= 1'b1;
          end else if (read_clear) begin
            status_reg[i] <= 1'b0;
          end
        end
      end else begin : g_rsvd
        assign status_reg[i] = 1'b0;
      end
    end
  endgenerate
endmodule

//--- verilog/phy_paged_status_diag_regs.sv
// paged status, diagnostic and control registers behind the management port
// Functional notes
// - negotiation error flag in copper bit 15 on any negotiation failure
// - copper events latch high, clear on read, zero on any reset
// - fiber bits 13:10 held invalid (zero) in serial gigabit mode
// - fiber bits 9, 8, 4 latch high on event, clear on read
// - mac bit 7 latches on buffer over/underflow; other bits zero
// - ram data read returns byte at ram address register location
// - fourth pair cable result: normal, short, open, test failed
// - reflection amplitude 1f positive, 10 zero, 00 negative
// - distance to fault on fourth pair in bits 7:0, resets zero
// - four 4-bit skew fields, fourth pair on top, 8 ns steps
// - 16-bit error counter counts both kinds, saturates, clears on read
// - bits 5 and 4 report channel crossover of pair groups
// - bits 3:0 give pair polarity, one negative
// - bit 6 shows diagnostic contents valid
// - page register reachable on any page, selects page for 0..28
// - page bit 15 enables automatic medium selection, resets one
// - copper control bit 15 selects transmitter class, resets zero
// - bit 8 enables detection; bits 7:4 drop hysteresis, reset 4
// - bits 3:2 select 100 Mb/s test output sequence
// - bit 1 forces negative 10 Mb/s receive polarity
`include "phy_regs_defines.svh"
module phy_paged_status_diag_regs (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   soft_rst,
  input  wire logic                   reg_rd,
  input  wire logic                   reg_wr,
  input  wire phy_regs_pkg::reg_num_t reg_addr,
  input  wire phy_regs_pkg::reg_word_t reg_wdata,
  output phy_regs_pkg::reg_word_t     reg_rdata,
  input  wire logic                   serial_gig_mode,
  input  wire logic                   ms_resolve_fail,
  input  wire logic                   parallel_detect_fault,
  input  wire logic                   no_common_mode,
  input  wire logic                   link_fail_after_neg,
  input  wire logic [14:0]            copper_events,
  input  wire logic [5:0]             fiber_events,
  input  wire logic                   elastic_buf_error,
  input  wire logic                   rx_symbol_error,
  input  wire logic                   rx_false_carrier,
  input  wire logic [7:0]             ram_rdata,
  output logic      [7:0]             ram_addr,
  output logic                        ram_we,
  output logic      [7:0]             ram_wdata,
  input  wire logic [1:0]             cable_result,
  input  wire logic [4:0]             cable_amplitude,
  input  wire logic [7:0]             cable_distance,
  input  wire logic [15:0]            pair_skew_in,
  input  wire logic                   diag_valid,
  input  wire logic                   cd_crossover,
  input  wire logic                   ab_crossover,
  input  wire logic [3:0]             pair_polarity,
  output logic                        auto_medium_sel,
  output logic [7:0]                  page_num,
  output logic                        tx_class_a,
  output logic                        pd_detect_en,
  output logic [3:0]                  pd_drop_hyst,
  output phy_regs_pkg::test_select_t  test_select,
  output logic                        force_neg_polarity
);
  import phy_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage
  reg_word_t page_reg;
  reg_word_t ctrl2_reg;
  logic [7:0] ram_addr_reg;
  reg_word_t rdata_reg;
  reg_word_t copper_status;
  reg_word_t fiber_status;
  reg_word_t mac_status;
  reg_word_t rxerr_count;
  reg_word_t copper_ev;
  reg_word_t fiber_ev;
  reg_word_t mac_ev;
  logic rd_copper;
  logic rd_fiber;
  logic rd_mac;
  logic rd_rxerr;
  logic neg_error;

  // page select and registers above 28 ignore the page
  function automatic logic hit(input reg_num_t a, input reg_num_t r,
                               input logic [7:0] pg, input logic [7:0] p);
    hit = (a == r) && ((r > `REG_PAGED_LAST) || (r == `REG_PAGE_SELECT)
                       || (pg == p));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // event gathering
  // any negotiation failure sets bit 15
  assign neg_error = ms_resolve_fail | parallel_detect_fault |
                     no_common_mode | link_fail_after_neg;

  // copper events in 14:8, 6:4, 2:0
  assign copper_ev = {neg_error, copper_events[14:8], 1'b0,
                      copper_events[6:4], 1'b0, copper_events[2:0]};

  // fiber_events: 13..10 at [5:2], symbol [1], false carrier [0]; energy
  // detect taken from copper_events[3], a slot the copper bank masks off, goes to bit 4
  assign fiber_ev = {2'b00, fiber_events[5:2], fiber_events[1:0],
                     3'b000, copper_events[3], 4'h0};

  // elastic buffer error to bit 7
  assign mac_ev = {8'h00, elastic_buf_error, 7'h00};

  assign rd_copper = reg_rd & hit(reg_addr, `REG_EVENT_STATUS,
                                  page_reg[7:0], `PAGE_COPPER);
  assign rd_fiber  = reg_rd & hit(reg_addr, `REG_EVENT_STATUS,
                                  page_reg[7:0], `PAGE_FIBER);
  assign rd_mac    = reg_rd & hit(reg_addr, `REG_EVENT_STATUS,
                                  page_reg[7:0], `PAGE_MAC);
  assign rd_rxerr  = reg_rd & reg_addr == `REG_RXERR_SWAP &&
                     (page_reg[7:0] == `PAGE_COPPER ||
                      page_reg[7:0] == `PAGE_FIBER);

  latched_high_bank #(
    .WIDTH (16),
    .MASK  (`COPPER_EVENT_MASK)
  ) u_copper (
    .clk        (clk),
    .rst_b      (rst_b),
    .soft_rst   (soft_rst),
    .event_in   (copper_ev),
    .read_clear (rd_copper),
    .status     (copper_status)
  );

  latched_high_bank #(
    .WIDTH (16),
    .MASK  (`FIBER_EVENT_MASK)
  ) u_fiber (
    .clk        (clk),
    .rst_b      (rst_b),
    .soft_rst   (soft_rst),
    .event_in   (fiber_ev),
    .read_clear (rd_fiber),
    .status     (fiber_status)
  );

  latched_high_bank #(
    .WIDTH (16),
    .MASK  (`MAC_EVENT_MASK)
  ) u_mac (
    .clk        (clk),
    .rst_b      (rst_b),
    .soft_rst   (soft_rst),
    .event_in   (mac_ev),
    .read_clear (rd_mac),
    .status     (mac_status)
  );

  rx_error_counter #(
    .WIDTH (16)
  ) u_rxerr (
    .clk           (clk),
    .rst_b         (rst_b),
    .symbol_err    (rx_symbol_error),
    .false_carrier (rx_false_carrier),
    .read_clear    (rd_rxerr),
    .count         (rxerr_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // writable registers; software reset retains them
  // page register on any page
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_reg <= `PAGE_RESET;
    end else if (reg_wr && reg_addr == `REG_PAGE_SELECT) begin
      page_reg <= reg_wdata & `PAGE_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl2_reg <= `CTRL2_RESET;
    end else if (reg_wr && hit(reg_addr, `REG_COPPER_CTRL2,
                               page_reg[7:0], `PAGE_COPPER)) begin
      ctrl2_reg <= reg_wdata & `CTRL2_WRITE_MASK;
    end
  end

  // ram byte address, page 4
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ram_addr_reg <= 8'h00;
    end else if (reg_wr && hit(reg_addr, `REG_RAM_ADDR_SKEW,
                               page_reg[7:0], `PAGE_NVM)) begin
      ram_addr_reg <= reg_wdata[7:0];
    end
  end

  // ram write uses address already held
  assign ram_we    = reg_wr & hit(reg_addr, `REG_EVENT_STATUS,
                                  page_reg[7:0], `PAGE_NVM);
  assign ram_wdata = reg_wdata[7:0];
  assign ram_addr  = ram_addr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; value captured in the read cycle, clears land after it
  // capture before clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd) begin
      rdata_reg <= 16'h0000;
      case (reg_addr)
        `REG_EVENT_STATUS: begin
          case (page_reg[7:0])
            `PAGE_COPPER: rdata_reg <= copper_status;
            `PAGE_FIBER: rdata_reg <= serial_gig_mode ?
                           (fiber_status & ~`FIBER_SERIAL_MASK) :
                           fiber_status;
            `PAGE_MAC: rdata_reg <= mac_status;
            `PAGE_NVM: rdata_reg <= {8'h00, ram_rdata};
            `PAGE_CABLE: rdata_reg <= {1'b0, cable_result,
                                       cable_amplitude, cable_distance};
            default: rdata_reg <= 16'h0000;
          endcase
        end
        `REG_RAM_ADDR_SKEW: begin
          case (page_reg[7:0])
            `PAGE_NVM: rdata_reg <= {8'h00, ram_addr_reg};
            `PAGE_CABLE: rdata_reg <= pair_skew_in;
            default: rdata_reg <= 16'h0000;
          endcase
        end
        `REG_RXERR_SWAP: begin
          case (page_reg[7:0])
            `PAGE_COPPER, `PAGE_FIBER: rdata_reg <= rxerr_count;
            `PAGE_CABLE: rdata_reg <= {9'h000, diag_valid, cd_crossover,
                                       ab_crossover, pair_polarity};
            default: rdata_reg <= 16'h0000;
          endcase
        end
        `REG_PAGE_SELECT: rdata_reg <= page_reg;
        `REG_COPPER_CTRL2: begin
          if (page_reg[7:0] == `PAGE_COPPER) begin
            rdata_reg <= ctrl2_reg;
          end
        end
        default: rdata_reg <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // control outputs
  // automatic medium selection
  assign auto_medium_sel    = page_reg[`PAGE_AUTO_BIT];
  assign page_num           = page_reg[7:0];
  assign tx_class_a         = ctrl2_reg[15];
  assign pd_detect_en       = ctrl2_reg[8];
  assign pd_drop_hyst       = ctrl2_reg[7:4];
  assign test_select        = test_select_t'(ctrl2_reg[3:2]);
  assign force_neg_polarity = ctrl2_reg[1];
endmodule

//--- verilog/phy_regs_defines.svh
// offsets, field positions, reset values and timing counts for the bank
`ifndef PHY_REGS_DEFINES_SVH
`define PHY_REGS_DEFINES_SVH
`define REG_EVENT_STATUS   5'h13
`define REG_RAM_ADDR_SKEW  5'h14
`define REG_RXERR_SWAP     5'h15
`define REG_PAGE_SELECT    5'h16
`define REG_COPPER_CTRL2   5'h1a
`define REG_PAGED_LAST     5'h1c
`define PAGE_COPPER        8'h00
`define PAGE_FIBER         8'h01
`define PAGE_MAC           8'h02
`define PAGE_NVM           8'h04
`define PAGE_CABLE         8'h05
`define COPPER_EVENT_MASK  16'hff77
`define FIBER_EVENT_MASK   16'h3f10
`define FIBER_SERIAL_MASK  16'h3c00
`define MAC_EVENT_MASK     16'h0080
`define PAGE_AUTO_BIT      15
`define PAGE_RESET         16'h8000
`define PAGE_WRITE_MASK    16'h80ff
`define CTRL2_RESET        16'h0040
`define CTRL2_WRITE_MASK   16'hfdfe
`define RXERR_MAX          16'hffff
`define SKEW_STEP_NS       8
`define DROP_HYST_STEP_S   5
`define TEST_SEQ_LONG_NS   112
`define TEST_SEQ_SHORT_NS  16
`endif

//--- verilog/phy_regs_pkg.sv
// types shared by the management register bank
package phy_regs_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [4:0]  reg_num_t;
  typedef enum logic [1:0] {
    cable_normal,
    cable_short,
    cable_open,
    cable_fail
  } cable_result_t;
  typedef enum logic [1:0] {
    test_normal_a,
    test_normal_b,
    test_seq_long,
    test_seq_short
  } test_select_t;
endpackage

//--- verilog/rx_error_counter.sv
// saturating receive error counter, cleared on read
module rx_error_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             symbol_err,
  input  wire logic             false_carrier,
  input  wire logic             read_clear,
  output logic      [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic [WIDTH-1:0] base;
  logic [1:0]       incr;
  logic [WIDTH:0]   sum;

  assign count = count_reg;

  // both error kinds, peg at max
  always_comb begin
    base = read_clear ? '0 : count_reg;
    incr = {1'b0, symbol_err} + {1'b0, false_carrier};
    sum  = {1'b0, base} + {{(WIDTH-1){1'b0}}, incr};
    if (sum[WIDTH]) begin
      count_next = '1;
    end else begin
      count_next = sum[WIDTH-1:0];
    end
  end

  // software reset retains the count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule
